// ===== clksrc_pkg.sv
// Purpose: Shared constants and types for the clock source mode control block
// Assumes: One 100 MHz system clock; byte-wide register port
// Notes:   Offsets are indices on the plain register port
package clksrc_pkg;

  localparam int unsigned ADDR_W       = 3;
  localparam logic [2:0]  OFF_CTRL_ONE = 3'h0;
  localparam logic [2:0]  OFF_CTRL_TWO = 3'h1;
  localparam logic [2:0]  OFF_TRIM     = 3'h2;
  localparam logic [2:0]  OFF_STATUS   = 3'h4;
  localparam logic [2:0]  OFF_CTRL_IRQ = 3'h5;

  localparam int unsigned LOL_BIT      = 7;
  localparam int unsigned LOCK_BIT     = 6;
  localparam int unsigned RSVD_BIT     = 5;
  localparam int unsigned REFST_BIT    = 4;
  localparam int unsigned OUTST_LSB    = 2;
  localparam int unsigned LOSS_OF_LOCK_IRQ_ENABLE_BIT    = 5;

  localparam logic [1:0]  SRC_FLL      = 2'h0;
  localparam logic [1:0]  SRC_INT      = 2'h1;
  localparam logic [1:0]  SRC_EXT      = 2'h2;
  localparam logic [1:0]  SRC_RSVD     = 2'h3;

  localparam logic [7:0]  CTRL_ONE_RST = 8'h04;
  localparam logic [7:0]  CTRL_TWO_RST = 8'h00;
  localparam logic [7:0]  TRIM_RST     = 8'h80;
  localparam logic [7:0]  CTRL_IRQ_RST = 8'h00;

  localparam int unsigned LOOP_MULT    = 1024;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned LOCK_SETTLE_NS = 1000;
  localparam int unsigned LOCK_SETTLE_CYC = (LOCK_SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [1:0] output_source_select;
    logic [2:0] reference_divider;
    logic       reference_select;
    logic       internal_ref_output_enable;
    logic       internal_ref_stop_enable;
  } clksrc_ctrl_one_t;

  typedef struct packed {
    logic [2:0] bus_divider;
    logic       rsvd_hi;
    logic       loop_disable_in_bypass;
    logic [2:0] rsvd_lo;
  } clksrc_ctrl_two_t;

  typedef struct packed {
    logic ext_ref_ok;
    logic loop_locked;
    logic stop_req;
    logic background_debug_mode;
  } clksrc_pins_t;

  typedef enum logic [2:0] {
    engaged_internal_mode,
    engaged_external_mode,
    bypass_internal_mode,
    bypass_internal_lowpower_mode,
    bypass_external_mode,
    bypass_external_lowpower_mode,
    stop_mode
  } clksrc_mode_t;

endpackage : clksrc_pkg

// ===== clksrc_sync.sv
// Purpose: Two-stage synchroniser for a bundle of levels
// Assumes: Inputs are levels, not pulses
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module clksrc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] stab_r;

  initial begin
    if (W < 1) $error("clksrc_sync: W must be at least 1");
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= '0;
      stab_r <= '0;
    end else begin
      meta_r <= d_in;
      stab_r <= meta_r;
    end
  end

  assign q_out = stab_r;
endmodule : clksrc_sync

// ===== clksrc_bus_div.sv
// Purpose: Bus clock enable divider, divide by two to the power of the field
// Assumes: Division field may change at any cycle
// Notes:   The mask is decoded live, so a new ratio acts at once
`timescale 1ns/10ps
module clksrc_bus_div #(
  parameter int unsigned DIV_W = 3
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  input  wire logic [DIV_W-1:0] bus_div_in,
  input  wire logic             run_in,
  output logic                  tick_out
);
  localparam int unsigned CNT_W = (1 << DIV_W) - 1;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] mask;

  initial begin
    if (DIV_W < 1 || DIV_W > 4) $error("clksrc_bus_div: DIV_W out of range");
  end

  function automatic logic [CNT_W-1:0] div_mask(input logic [DIV_W-1:0] d);
    logic [CNT_W:0] one;
    one = '0;
    one[0] = 1'b1;
    div_mask = CNT_W'((one << d) - one);
  endfunction : div_mask

  assign mask = div_mask(bus_div_in);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r <= '0;
    end else if (run_in) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // Static while not running, so the output clock holds still in stop
  assign tick_out = run_in && ((cnt_r & mask) == mask);
endmodule : clksrc_bus_div

// ===== clksrc_ctrl.sv
// Purpose: Mode selection, source switching and lock status of the clock source
// Assumes: Pins arrive asynchronously; analog loop and oscillators sit outside
// Notes:   Main clock output is a one-cycle enable on the single system clock; reference clock output is a level
`timescale 1ns/10ps

// Notes on behaviour
// - Reference status bit 4 after synchronising
// - Output source status field after synchronising
// - Reserved status bits always read zero
// - Lock bit shows current loop lock
// - Default engaged internal, loop times 1024
// - Engaged external needs properly divided reference
// - Bypass internal keeps loop locked running
// - Bypass internal low power stops loop
// - Bypass external keeps loop locked running
// - Bypass external low power stops loop
// - Stop freezes clocks except enabled reference
// - Stop reverts oscillator, needs relock afterwards
// - Reference switch any time, then relock
// - Unavailable output source keeps previous one
// - Bus divider change acts immediately
// - Low power bit off keeps loop enabled
// - Loss of lock sticky, write one clears
// - Lock clears on reference, divider, trim, stop; trim clears it only while internal reference selected
module clksrc_ctrl
  import clksrc_pkg::*;
#(
  parameter int unsigned DIV_W = 3
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_b_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [7:0]        rdata_out,
  input  wire clksrc_pins_t      pins_in,
  output logic                   main_clock_output_out,
  output logic                   internal_ref_clock_output_out,
  output logic      [1:0]        ref_mux_sel_out,
  output logic                   internal_ref_enable_out,
  output logic                   external_ref_enable_out,
  output logic                   loop_enable_out,
  output logic                   loop_restart_out,
  output logic                   oscillator_revert_out,
  output logic      [2:0]        reference_divider_out,
  output logic      [7:0]        trim_out,
  output logic                   loss_of_lock_irq_out,
  output clksrc_mode_t           mode_out
);
  clksrc_ctrl_one_t ctrl_one_r;
  clksrc_ctrl_two_t ctrl_two_r;
  logic [7:0]       trim_r;
  logic             loss_of_lock_irq_enable_r;
  clksrc_pins_t     pins_s;
  logic             ref_sel_act_r;
  logic [1:0]       out_sel_act_r;
  logic             ref_sel_prev_r;
  logic             stop_prev_r;
  logic             lock_r;
  logic             loss_of_lock_flag_r;
  logic [7:0]       settle_r;
  logic             relock_evt_r;
  logic [2:0]       stat_s;
  logic [7:0]       rdata_r;
  logic             restart_r;
  clksrc_mode_t     mode_r;
  clksrc_mode_t     mode_nxt;
  logic             wr_one;
  logic             wr_two;
  logic             wr_trim;
  logic             wr_stat;
  logic             wr_irq;
  logic             stop_s;
  logic             lowpower;
  logic             loop_on;
  logic             relock_evt;
  logic             out_req_ok;
  logic             div_tick;

  localparam logic [7:0] SETTLE_LAST = 8'(LOCK_SETTLE_CYC - 1);

  initial begin
    if (DIV_W != 3) $error("clksrc_ctrl: bus divider field is three bits");
    if (LOCK_SETTLE_CYC > 256) $error("clksrc_ctrl: settle count too wide");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_one  = wr_in && hit(addr_in, OFF_CTRL_ONE);
  assign wr_two  = wr_in && hit(addr_in, OFF_CTRL_TWO);
  assign wr_trim = wr_in && hit(addr_in, OFF_TRIM);
  assign wr_stat = wr_in && hit(addr_in, OFF_STATUS);
  assign wr_irq  = wr_in && hit(addr_in, OFF_CTRL_IRQ);

  // Asynchronous pins pass two flip-flops before use
  clksrc_sync #(.W(4)) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .d_in       (pins_in),
    .q_out      (pins_s)
  );

  assign stop_s   = pins_s.stop_req;
  assign lowpower = ctrl_two_r.loop_disable_in_bypass && !pins_s.background_debug_mode;

  // Loop runs in engaged modes, and in bypass unless low power outside debug
  assign loop_on = !stop_s && ((out_sel_act_r == SRC_FLL) || !lowpower);

  // Register writes; any field may change at any time
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_one_r <= clksrc_ctrl_one_t'(CTRL_ONE_RST);
    end else if (wr_one) begin
      ctrl_one_r <= clksrc_ctrl_one_t'(wdata_in);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_two_r <= clksrc_ctrl_two_t'(CTRL_TWO_RST);
    end else if (wr_two) begin
      ctrl_two_r.bus_divider            <= wdata_in[7:5];
      ctrl_two_r.loop_disable_in_bypass <= wdata_in[3];
      ctrl_two_r.rsvd_hi                <= 1'b0;
      ctrl_two_r.rsvd_lo                <= 3'h0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trim_r  <= TRIM_RST;
      loss_of_lock_irq_enable_r <= 1'b0;
    end else begin
      if (wr_trim) begin
        trim_r <= wdata_in;
      end
      if (wr_irq) begin
        loss_of_lock_irq_enable_r <= wdata_in[LOSS_OF_LOCK_IRQ_ENABLE_BIT];
      end
    end
  end

  // Reference mux follows the request once the external source is good;
  // software should wait on the status bit before engaging external
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_sel_act_r <= 1'b1;
    end else if (ctrl_one_r.reference_select || pins_s.ext_ref_ok) begin
      ref_sel_act_r <= ctrl_one_r.reference_select;
    end
  end

  // Output mux moves only to a source that is actually available
  always_comb begin
    unique case (ctrl_one_r.output_source_select)
      SRC_FLL:  out_req_ok = !stop_s && ((out_sel_act_r == SRC_FLL) || !lowpower);
      SRC_INT:  out_req_ok = 1'b1;
      SRC_EXT:  out_req_ok = pins_s.ext_ref_ok;
      SRC_RSVD: out_req_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_sel_act_r <= SRC_FLL;
    end else if (out_req_ok) begin
      out_sel_act_r <= ctrl_one_r.output_source_select;
    end
  end

  // Status copies are taken from the mux selects through two stages
  clksrc_sync #(.W(3)) u_stat_sync (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .d_in       ({ref_sel_act_r, out_sel_act_r}),
    .q_out      (stat_s)
  );

  // Events that throw the loop out of lock
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_sel_prev_r <= 1'b1;
      stop_prev_r    <= 1'b0;
    end else begin
      ref_sel_prev_r <= ref_sel_act_r;
      stop_prev_r    <= stop_s;
    end
  end

  assign relock_evt = (ref_sel_prev_r != ref_sel_act_r)
                   || (wr_one && (wdata_in[5:3] != ctrl_one_r.reference_divider))
                   || (wr_trim && ref_sel_act_r && (wdata_in != trim_r))
                   || (stop_s && !stop_prev_r);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      relock_evt_r <= 1'b0;
    end else begin
      relock_evt_r <= relock_evt;
    end
  end

  // Lock is trusted only after the detector holds steady for the settle time
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      settle_r <= 8'h00;
      lock_r   <= 1'b0;
    end else if (relock_evt || relock_evt_r || !loop_on || !pins_s.loop_locked) begin
      settle_r <= 8'h00;
      lock_r   <= 1'b0;
    end else if (!lock_r) begin
      if (settle_r == SETTLE_LAST) begin
        lock_r <= 1'b1;
      end else begin
        settle_r <= settle_r + 8'h01;
      end
    end
  end

  // Only a genuine drop of the detector counts; a set beats a clear
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      loss_of_lock_flag_r <= 1'b0;
    end else if (lock_r && loop_on && !pins_s.loop_locked && !relock_evt) begin
      loss_of_lock_flag_r <= 1'b1;
    end else if (wr_stat && wdata_in[LOL_BIT]) begin
      loss_of_lock_flag_r <= 1'b0;
    end
  end

  // Pulse to restart the loop, and hold the oscillator at reset value in stop
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= relock_evt;
    end
  end

  // Mode decode for visibility
  always_comb begin
    if (stop_s) begin
      mode_nxt = stop_mode;
    end else begin
      unique case (out_sel_act_r)
        SRC_FLL:  mode_nxt = ref_sel_act_r ? engaged_internal_mode : engaged_external_mode;
        SRC_INT:  mode_nxt = lowpower ? bypass_internal_lowpower_mode : bypass_internal_mode;
        SRC_EXT:  mode_nxt = lowpower ? bypass_external_lowpower_mode : bypass_external_mode;
        SRC_RSVD: mode_nxt = mode_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_r <= engaged_internal_mode;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Register read path, one cycle latency; unmapped reads give zero
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        OFF_CTRL_ONE: rdata_r <= 8'(ctrl_one_r);
        OFF_CTRL_TWO: rdata_r <= 8'(ctrl_two_r);
        OFF_TRIM:     rdata_r <= trim_r;
        OFF_STATUS:   rdata_r <= {loss_of_lock_flag_r, lock_r, 1'b0, stat_s, 2'h0};
        OFF_CTRL_IRQ: rdata_r <= 8'(loss_of_lock_irq_enable_r) << LOSS_OF_LOCK_IRQ_ENABLE_BIT;
        default:      rdata_r <= 8'h00;
      endcase
    end
  end

  clksrc_bus_div #(.DIV_W(DIV_W)) u_bus_div (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .bus_div_in (ctrl_two_r.bus_divider),
    .run_in     (!stop_s),
    .tick_out   (div_tick)
  );

  assign rdata_out                     = rdata_r;
  assign main_clock_output_out         = div_tick;
  assign internal_ref_clock_output_out = ctrl_one_r.internal_ref_output_enable
                                      && (!stop_s || ctrl_one_r.internal_ref_stop_enable);
  assign ref_mux_sel_out               = out_sel_act_r;
  // Internal reference stays on whenever an internal mode uses it
  assign internal_ref_enable_out       = ref_sel_act_r || (out_sel_act_r == SRC_INT)
                                      || internal_ref_clock_output_out;
  assign external_ref_enable_out       = !ref_sel_act_r || (out_sel_act_r == SRC_EXT);
  assign loop_enable_out               = loop_on;
  assign loop_restart_out              = restart_r;
  assign oscillator_revert_out         = stop_s;
  assign reference_divider_out         = ctrl_one_r.reference_divider;
  assign trim_out                      = trim_r;
  assign loss_of_lock_irq_out          = loss_of_lock_flag_r && loss_of_lock_irq_enable_r;
  assign mode_out                      = mode_r;
endmodule : clksrc_ctrl

// ===== clksrc_ctrl_monitor.sv
// Purpose: Port-level assertions for the clock source mode control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Status timing is only judged once the mux select has settled
`timescale 1ns/10ps
module clksrc_ctrl_monitor
  import clksrc_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              rst_b_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0]        wdata_in,
  input wire logic              wr_in,
  input wire logic              rd_in,
  input wire logic [7:0]        rdata_out,
  input wire clksrc_pins_t      pins_in,
  input wire logic              main_clock_output_out,
  input wire logic [1:0]        ref_mux_sel_out,
  input wire logic              internal_ref_enable_out,
  input wire logic              external_ref_enable_out,
  input wire logic              loop_enable_out,
  input wire logic              oscillator_revert_out,
  input wire logic [2:0]        reference_divider_out,
  input wire clksrc_mode_t      mode_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_rsvd_zero;
    rd_in && addr_in == OFF_STATUS |=> rdata_out[RSVD_BIT] == 1'b0 && rdata_out[1:0] == 2'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved status bits not zero");

  property p_no_rsvd_src;
    ref_mux_sel_out != SRC_RSVD;
  endproperty
  a_no_rsvd_src: assert property (p_no_rsvd_src) else $error("reserved source selected");

  // Only a settled select is compared, the sync delay is free otherwise
  property p_out_status;
    rd_in && addr_in == OFF_STATUS && ref_mux_sel_out == $past(ref_mux_sel_out)
      && ref_mux_sel_out == $past(ref_mux_sel_out, 2) |=> rdata_out[3:2] == $past(ref_mux_sel_out);
  endproperty
  a_out_status: assert property (p_out_status) else $error("source status differs from mux");

  property p_lock_needs_pin;
    rd_in && addr_in == OFF_STATUS && !pins_in.loop_locked && !$past(pins_in.loop_locked)
      && !$past(pins_in.loop_locked, 2) && !$past(pins_in.loop_locked, 3) && !$past(pins_in.loop_locked, 4)
      |=> !rdata_out[LOCK_BIT];
  endproperty
  a_lock_needs_pin: assert property (p_lock_needs_pin) else $error("lock shown without detector");

  property p_stop_quiet;
    oscillator_revert_out |-> !main_clock_output_out;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("main clock pulsed in stop");

  property p_bypass_internal_lowpower_mode;
    mode_out == bypass_internal_lowpower_mode |-> !$past(loop_enable_out) && $past(internal_ref_enable_out);
  endproperty
  a_bypass_internal_lowpower_mode: assert property (p_bypass_internal_lowpower_mode) else $error("internal low power enables wrong");

  property p_bypass_external_lowpower_mode;
    mode_out == bypass_external_lowpower_mode |-> !$past(loop_enable_out) && $past(external_ref_enable_out);
  endproperty
  a_bypass_external_lowpower_mode: assert property (p_bypass_external_lowpower_mode) else $error("external low power enables wrong");

  property p_fei;
    mode_out == engaged_internal_mode |-> $past(loop_enable_out) && $past(internal_ref_enable_out);
  endproperty
  a_fei: assert property (p_fei) else $error("engaged internal enables wrong");

  property p_stop_mode;
    $rose(oscillator_revert_out) |-> ##[0:2] mode_out == stop_mode;
  endproperty
  a_stop_mode: assert property (p_stop_mode) else $error("stop not entered");

  property p_div_load;
    wr_in && addr_in == OFF_CTRL_ONE |=> reference_divider_out == $past(wdata_in[5:3]);
  endproperty
  a_div_load: assert property (p_div_load) else $error("reference divider not loaded");
endmodule : clksrc_ctrl_monitor

bind clksrc_ctrl clksrc_ctrl_monitor u_mon (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pins_in(pins_in),
  .main_clock_output_out(main_clock_output_out), .ref_mux_sel_out(ref_mux_sel_out),
  .internal_ref_enable_out(internal_ref_enable_out), .external_ref_enable_out(external_ref_enable_out),
  .loop_enable_out(loop_enable_out), .oscillator_revert_out(oscillator_revert_out),
  .reference_divider_out(reference_divider_out), .mode_out(mode_out)
);

// ===== tb_clksrc_ctrl.sv
// Purpose: Self-checking bench for the clock source mode control block
// Assumes: Bench drives every input at the rising edge
// Notes:   Read results are queued by the driver, checked by a watcher
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin miscompares++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb_clksrc_ctrl
  import clksrc_pkg::*;
;
  typedef struct packed {
    logic [1:0]   o;
    logic         r;
    logic         lp;
    logic         dbg;
    clksrc_mode_t m;
    logic         le;
  } clksrc_row_t;

  logic              clk_sys_in = 1'b0;
  logic              rst_b_in   = 1'b0;
  logic [ADDR_W-1:0] addr_in    = '0;
  logic [7:0]        wdata_in   = '0;
  logic              wr_in      = 1'b0;
  logic              rd_in      = 1'b0;
  clksrc_pins_t      pins_in    = 4'h8;
  logic [7:0]        rdata_out, trim_out, exp_v, prev;
  logic              main_clock_output_out, internal_ref_clock_output_out, internal_ref_enable_out;
  logic              external_ref_enable_out, loop_enable_out, loop_restart_out;
  logic              oscillator_revert_out, loss_of_lock_irq_out;
  logic [1:0]        ref_mux_sel_out;
  logic [2:0]        reference_divider_out;
  clksrc_mode_t      mode_out;
  logic [7:0]        exp_q[$];
  logic              rd_q = 1'b0;
  logic [31:0]       lfsr = 32'hC24D;
  int                miscompares = 0;
  int                checked = 0;
  int                restart_cnt = 0;
  int                n, c;
  clksrc_row_t       rows [7] = '{
    '{2'h1, 1'b1, 1'b0, 1'b0, bypass_internal_mode, 1'b1},
    '{2'h1, 1'b1, 1'b1, 1'b0, bypass_internal_lowpower_mode, 1'b0},
    '{2'h1, 1'b1, 1'b1, 1'b1, bypass_internal_mode, 1'b1},
    '{2'h2, 1'b0, 1'b0, 1'b0, bypass_external_mode, 1'b1},
    '{2'h2, 1'b0, 1'b1, 1'b0, bypass_external_lowpower_mode, 1'b0},
    '{2'h0, 1'b0, 1'b0, 1'b0, engaged_external_mode, 1'b1},
    '{2'h0, 1'b1, 1'b0, 1'b0, engaged_internal_mode, 1'b1}};

  always #5 clk_sys_in = ~clk_sys_in;

  clksrc_ctrl DUT (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pins_in(pins_in),
    .main_clock_output_out(main_clock_output_out), .internal_ref_clock_output_out(internal_ref_clock_output_out),
    .ref_mux_sel_out(ref_mux_sel_out), .internal_ref_enable_out(internal_ref_enable_out),
    .external_ref_enable_out(external_ref_enable_out), .loop_enable_out(loop_enable_out),
    .loop_restart_out(loop_restart_out), .oscillator_revert_out(oscillator_revert_out),
    .reference_divider_out(reference_divider_out), .trim_out(trim_out),
    .loss_of_lock_irq_out(loss_of_lock_irq_out), .mode_out(mode_out)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // One bus cycle; for a read, d is the value expected back
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    wr_in    <= w;
    rd_in    <= ~w;
    addr_in  <= a;
    wdata_in <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clk_sys_in);
  endtask : bus

  task automatic idle(input int k);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (k) @(posedge clk_sys_in);
  endtask : idle

  task automatic ticks(input int k, output int cnt);
    cnt = 0;
    repeat (k) begin
      @(posedge clk_sys_in);
      cnt += int'(main_clock_output_out === 1'b1);
    end
  endtask : ticks

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  always @(posedge clk_sys_in) begin
    rd_q <= rd_in;
    if (loop_restart_out === 1'b1) restart_cnt <= restart_cnt + 1;
    if (rd_q) begin
      exp_v = exp_q.pop_front();
      `CHK("rdata", exp_v, rdata_out)
    end
  end

  initial begin
    #100000;
    miscompares++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    bus(0, OFF_CTRL_ONE, CTRL_ONE_RST);
    bus(0, OFF_CTRL_TWO, CTRL_TWO_RST);
    bus(0, OFF_TRIM, TRIM_RST);
    bus(0, OFF_CTRL_IRQ, CTRL_IRQ_RST);
    bus(0, OFF_STATUS, 8'h10);
    bus(0, 3'h3, 8'h00);
    bus(0, 3'h7, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      bus(1, OFF_CTRL_TWO, lfsr[7:0]);
      bus(0, OFF_CTRL_TWO, lfsr[7:0] & 8'hE8);
      bus(1, OFF_TRIM, lfsr[15:8]);
      bus(0, OFF_TRIM, lfsr[15:8]);
      `CHK("trim_out", lfsr[15:8], trim_out)
      bus(1, OFF_CTRL_IRQ, lfsr[23:16]);
      bus(0, OFF_CTRL_IRQ, lfsr[23:16] & 8'h20);
    end
    prev = 8'h10;
    foreach (rows[i]) begin
      pins_in.background_debug_mode <= rows[i].dbg;
      bus(1, OFF_CTRL_TWO, {4'h0, rows[i].lp, 3'h0});
      bus(1, OFF_CTRL_ONE, {rows[i].o, 3'h0, rows[i].r, 2'h0});
      bus(0, OFF_STATUS, prev);
      idle(6);
      prev = {3'h0, rows[i].r, rows[i].o, 2'h0};
      bus(0, OFF_STATUS, prev);
      idle(1);
      `CHK("mode", rows[i].m, mode_out)
      `CHK("loop_en", rows[i].le, loop_enable_out)
    end
    // External reference missing: the old source has to stay
    pins_in.ext_ref_ok <= 1'b0;
    idle(4);
    bus(1, OFF_CTRL_ONE, 8'h80);
    idle(6);
    bus(0, OFF_STATUS, 8'h10);
    `CHK("mux", SRC_FLL, ref_mux_sel_out)
    // Reserved source code is never available, the loop output has to stay
    bus(1, OFF_CTRL_ONE, 8'hC4);
    idle(6);
    `CHK("mux_rsvd", SRC_FLL, ref_mux_sel_out)
    `CHK("mode_rsvd", engaged_internal_mode, mode_out)
    pins_in.ext_ref_ok <= 1'b1;
    bus(1, OFF_CTRL_ONE, 8'h04);
    pins_in.loop_locked <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      n = restart_cnt;
      idle(LOCK_SETTLE_CYC + 10);
      bus(0, OFF_STATUS, 8'h50);
      bus(1, k ? OFF_TRIM : OFF_CTRL_ONE, k ? ~trim_out : 8'h0C);
      idle(2);
      bus(0, OFF_STATUS, 8'h10);
      idle(1);
      `CHK("restart", 1'b1, restart_cnt > n)
    end
    bus(1, OFF_CTRL_IRQ, 8'h20);
    idle(LOCK_SETTLE_CYC + 10);
    pins_in.loop_locked <= 1'b0;
    idle(6);
    `CHK("irq", 1'b1, loss_of_lock_irq_out)
    bus(1, OFF_STATUS, 8'h7F);
    bus(0, OFF_STATUS, 8'h90);
    bus(1, OFF_STATUS, 8'h80);
    bus(0, OFF_STATUS, 8'h10);
    idle(1);
    `CHK("irq", 1'b0, loss_of_lock_irq_out)
    pins_in.loop_locked <= 1'b1;
    bus(1, OFF_CTRL_ONE, 8'h0F);
    idle(LOCK_SETTLE_CYC + 10);
    pins_in.stop_req <= 1'b1;
    idle(6);
    `CHK("revert", 1'b1, oscillator_revert_out)
    `CHK("mode", stop_mode, mode_out)
    `CHK("irclk", 1'b1, internal_ref_clock_output_out)
    ticks(16, c);
    `CHK("stop_ticks", 0, c)
    bus(1, OFF_CTRL_ONE, 8'h0E);
    idle(2);
    `CHK("irclk", 1'b0, internal_ref_clock_output_out)
    pins_in.stop_req <= 1'b0;
    idle(6);
    bus(0, OFF_STATUS, 8'h10);
    // Counting over a whole number of periods makes the phase irrelevant
    for (int d = 0; d < 8; d++) begin
      bus(1, OFF_CTRL_TWO, {d[2:0], 5'h0});
      idle(0);
      ticks(128, c);
      `CHK("ticks", 128 >> d, c)
    end
    idle(4);
    test_done();
  end
endmodule : tb_clksrc_ctrl
